// ---- rtl/pwmg_top.sv ----
/*
 * pwmg_top: 8-bit pwm generator with prescaler, half-rate source option
 * and two alternative output pins, registers reached over apb.
 * assumes: pclk is clk_sys_i, port data for each pin comes from the
 * same clock domain, and clk_sys_i stands in for the main oscillator.
 */
`timescale 1ns/1ps
// Behaviour
// - 8-bit pwm from oscillator or oscillator/2
// - control bit 2 selects output pin
// - period is 255*(n+1) source clocks
// - high time is period*m/255
// - enable initializes, periods start high
// - new settings apply from next period
// - low lead-in of (n+1) source clocks first

module pwmg_top
	import pwmg_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic port_pin_alt_a_i,
	input wire logic port_pin_alt_b_i,
	output logic pulse_out_pin_a_o,
	output logic pulse_out_pin_b_o
);

	////////////////////////////////////////////////////////////////////////////
	// configuration, generator and bus state
	logic [2:0] ctrl_reg;
	logic [7:0] presc_reg;
	logic [7:0] duty_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	pwmg_cfg_t cur_reg;
	pwmg_state_t state_reg;
	logic half_reg;
	logic [7:0] pre_cnt_reg;
	logic [7:0] per_cnt_reg;
	logic pulse_reg;
	logic wr_en;
	logic acc;
	logic map_hit;
	logic src_tick;
	logic pre_wrap;
	logic per_wrap;
	logic enable;

	// apb decode; every access completes in its first access cycle,
	// so pready is tied high and no wait state is ever inserted
	assign acc = psel_i && penable_i;
	assign wr_en = acc && pwrite_i;
	assign enable = ctrl_reg[PWMG_EN_BIT];
	assign pready_o = 1'b1;
	assign pslverr_o = pslverr_reg;
	assign prdata_o = prdata_reg;
	assign map_hit = (paddr_i == PWMG_CTRL_OFS) || (paddr_i == PWMG_PRESC_OFS)
		|| (paddr_i == PWMG_DUTY_OFS) || (paddr_i == PWMG_STAT_OFS);

	////////////////////////////////////////////////////////////////////////////
	// register writes, one-cycle access phase
	// writes land at the access edge; bits above each field are dropped
	// and unmapped offsets are ignored
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl_reg <= PWMG_CTRL_RST;
			presc_reg <= PWMG_PRESC_RST;
			duty_reg <= PWMG_DUTY_RST;
		end else if (wr_en) begin
			if (paddr_i == PWMG_CTRL_OFS) begin
				ctrl_reg <= pwdata_i[2:0];
			end else if (paddr_i == PWMG_PRESC_OFS) begin
				presc_reg <= pwdata_i[7:0];
			end else if (paddr_i == PWMG_DUTY_OFS) begin
				duty_reg <= pwdata_i[7:0];
			end
		end
	end

	// read data and error answer
	// read data is latched in the setup cycle so it stands unchanged
	// through the access cycle, whatever the generator does meanwhile
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else if (psel_i && !penable_i) begin
			pslverr_reg <= !map_hit;
			if (paddr_i == PWMG_CTRL_OFS) begin
				prdata_reg <= {29'h0, ctrl_reg};
			end else if (paddr_i == PWMG_PRESC_OFS) begin
				prdata_reg <= {24'h0, presc_reg};
			end else if (paddr_i == PWMG_DUTY_OFS) begin
				prdata_reg <= {24'h0, duty_reg};
			end else if (paddr_i == PWMG_STAT_OFS) begin
				prdata_reg <= {22'h0, per_cnt_reg, pulse_reg, state_reg == PWMG_RUN};
			end else begin
				prdata_reg <= 32'h0000_0000;
			end
		end else if (!psel_i) begin
			pslverr_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// count source: every clock or every second clock
	// the phase bit restarts in idle, so the first half-rate tick
	// always falls one clock after the lead-in begins
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			half_reg <= 1'b0;
		end else if (state_reg == PWMG_IDLE) begin
			half_reg <= 1'b0;
		end else begin
			half_reg <= !half_reg;
		end
	end

	// tick and wrap strobes of the prescaler and step counter
	assign src_tick = ctrl_reg[PWMG_SRC_BIT] ? 1'b1 : half_reg;
	assign pre_wrap = src_tick && (pre_cnt_reg == cur_reg.presc);
	assign per_wrap = pre_wrap && (per_cnt_reg == PWMG_PERIOD_LAST);

	// phase control and settings latch
	// settings reach cur_reg only on leaving idle and at a period boundary; a write in the
	// middle of a period therefore cannot bend the pulse in progress
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_reg <= PWMG_IDLE;
			cur_reg <= '{presc: PWMG_PRESC_RST, duty: PWMG_DUTY_RST};
		end else if (!enable) begin
			state_reg <= PWMG_IDLE;
		end else begin
			case (state_reg)
				PWMG_IDLE: begin
					state_reg <= PWMG_LEAD;
					cur_reg <= '{presc: presc_reg, duty: duty_reg};
				end
				PWMG_LEAD: begin
					if (pre_wrap) begin
						state_reg <= PWMG_RUN;
					end
				end
				default: begin
					if (per_wrap) begin
						cur_reg <= '{presc: presc_reg, duty: duty_reg};
					end
				end
			endcase
		end
	end

	// prescaler and period counters
	// the step counter only moves in run, so the lead-in lasts exactly
	// one prescaler pass before step 0
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pre_cnt_reg <= 8'h00;
			per_cnt_reg <= 8'h00;
		end else if (state_reg == PWMG_IDLE || !enable) begin
			pre_cnt_reg <= 8'h00;
			per_cnt_reg <= 8'h00;
		end else if (src_tick) begin
			if (pre_wrap) begin
				pre_cnt_reg <= 8'h00;
				if (state_reg == PWMG_RUN) begin
					per_cnt_reg <= per_wrap ? 8'h00 : per_cnt_reg + 8'h01;
				end
			end else begin
				pre_cnt_reg <= pre_cnt_reg + 8'h01;
			end
		end
	end

	// pulse level: high while step count below duty
	// at a boundary cur_reg is loaded in the same edge, so the level of
	// step 0 is taken from the duty register itself; disable drops the
	// level at once so status never shows a stale high
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pulse_reg <= 1'b0;
		end else if (state_reg == PWMG_RUN && enable) begin
			if (per_wrap) begin
				pulse_reg <= duty_reg != 8'h00;
			end else if (pre_wrap) begin
				pulse_reg <= (per_cnt_reg + 8'h01) < cur_reg.duty;
			end
		end else if (state_reg == PWMG_LEAD && enable && pre_wrap) begin
			pulse_reg <= cur_reg.duty != 8'h00;
		end else begin
			pulse_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pin routing; unused pin passes its port data
	// pins are registered, one clock behind the internal level; with the
	// generator off both pins serve as general port outputs
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pulse_out_pin_a_o <= 1'b0;
			pulse_out_pin_b_o <= 1'b0;
		end else if (enable && ctrl_reg[PWMG_PINSEL_BIT]) begin
			pulse_out_pin_a_o <= port_pin_alt_a_i;
			pulse_out_pin_b_o <= pulse_reg;
		end else if (enable) begin
			pulse_out_pin_a_o <= pulse_reg;
			pulse_out_pin_b_o <= port_pin_alt_b_i;
		end else begin
			pulse_out_pin_a_o <= port_pin_alt_a_i;
			pulse_out_pin_b_o <= port_pin_alt_b_i;
		end
	end

endmodule : pwmg_top

// ---- rtl/pwmg_pkg.sv ----
/*
 * pwmg_pkg: register map, field positions and reset values of the
 * prescaled 8-bit pulse generator.
 * assumes: a 32-bit APB slave with one register per aligned word.
 */
package pwmg_pkg;

	// register byte offsets
	localparam logic [7:0] PWMG_CTRL_OFS = 8'h00;
	localparam logic [7:0] PWMG_PRESC_OFS = 8'h04;
	localparam logic [7:0] PWMG_DUTY_OFS = 8'h08;
	localparam logic [7:0] PWMG_STAT_OFS = 8'h0c;

	// control field positions
	localparam int PWMG_EN_BIT = 0;
	localparam int PWMG_SRC_BIT = 1;
	localparam int PWMG_PINSEL_BIT = 2;

	// reset values
	localparam logic [2:0] PWMG_CTRL_RST = 3'h0;
	localparam logic [7:0] PWMG_PRESC_RST = 8'h00;
	localparam logic [7:0] PWMG_DUTY_RST = 8'h00;

	// last step count of an output period (255 steps per period)
	localparam logic [7:0] PWMG_PERIOD_LAST = 8'hfe;

	// generator phases
	typedef enum logic [1:0] {
		PWMG_IDLE,
		PWMG_LEAD,
		PWMG_RUN
	} pwmg_state_t;

	// period settings latched together at each period boundary
	typedef struct packed {
		logic [7:0] presc;
		logic [7:0] duty;
	} pwmg_cfg_t;

endpackage : pwmg_pkg

// ---- bench/pwmg_sva.sv ----
/* pwmg_sva: port checker of the pulse generator; assumes apb writes are seen on its ports. */
`timescale 1ns/1ps
module pwmg_sva
	import pwmg_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic port_pin_alt_a_i,
	input wire logic port_pin_alt_b_i,
	input wire logic pulse_out_pin_a_o,
	input wire logic pulse_out_pin_b_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	logic [2:0] ctrl_reg;
	wire logic en = ctrl_reg[PWMG_EN_BIT];
	wire logic sel = ctrl_reg[PWMG_PINSEL_BIT];
	// shadow of the control word
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) ctrl_reg <= PWMG_CTRL_RST;
		else if (psel_i && penable_i && pwrite_i && paddr_i == PWMG_CTRL_OFS) ctrl_reg <= pwdata_i[2:0];
	end
	////////////////
	sequence s_off; !en [*3]; endsequence
	sequence s_a; (en && !sel) [*3]; endsequence
	sequence s_b; (en && sel) [*3]; endsequence
	property p_rdy; psel_i && penable_i |-> pready_o; endproperty
	a_rdy: assert property (p_rdy) else $error("ready");
	property p_err; psel_i && penable_i && paddr_i > PWMG_STAT_OFS |-> pslverr_o; endproperty
	a_err: assert property (p_err) else $error("slverr");
	property p_off; s_off |-> pulse_out_pin_a_o == $past(port_pin_alt_a_i); endproperty
	a_off: assert property (p_off) else $error("off");
	property p_sel_a; s_a |-> pulse_out_pin_b_o == $past(port_pin_alt_b_i); endproperty
	a_sel_a: assert property (p_sel_a) else $error("pin a");
	property p_sel_b; s_b |-> pulse_out_pin_a_o == $past(port_pin_alt_a_i); endproperty
	a_sel_b: assert property (p_sel_b) else $error("pin b");
	property p_lead_a; $rose(en) && !sel |=> (!pulse_out_pin_a_o) [*2]; endproperty
	a_lead_a: assert property (p_lead_a) else $error("lead a");
	property p_lead_b; $rose(en) && sel |=> (!pulse_out_pin_b_o) [*2]; endproperty
	a_lead_b: assert property (p_lead_b) else $error("lead b");
	property p_off_b; s_off |-> pulse_out_pin_b_o == $past(port_pin_alt_b_i); endproperty
	a_off_b: assert property (p_off_b) else $error("off b");
endmodule : pwmg_sva
bind pwmg_top pwmg_sva u_sva (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
	.paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .port_pin_alt_a_i(port_pin_alt_a_i),
	.port_pin_alt_b_i(port_pin_alt_b_i), .pulse_out_pin_a_o(pulse_out_pin_a_o),
	.pulse_out_pin_b_o(pulse_out_pin_b_o));

// ---- bench/pwmg_load.sv ----
/* pwmg_load: load on a pulse pin measuring high time and period; assumes the system clock. */
`timescale 1ns/1ps
module pwmg_load (
	input wire logic clk_i,
	input wire logic pin_i,
	output int hi_o,
	output int per_o
);
	int hcnt = 0;
	int pcnt = 0;
	logic pin_q = 1'b0;
	// count clocks between rising edges and while high
	always @(posedge clk_i) begin
		pin_q <= pin_i;
		pcnt <= pcnt + 1;
		if (pin_i) hcnt <= hcnt + 1;
		if (pin_i && !pin_q) begin
			per_o <= pcnt;
			pcnt <= 1;
			hcnt <= 1;
		end
		if (!pin_i && pin_q) hi_o <= hcnt;
	end
endmodule : pwmg_load

// ---- bench/pwmg_top_tb.sv ----
/* pwmg_top_tb: self-checking bench; assumes pwmg_top with loads on both pins. */
`timescale 1ns/1ps
module pwmg_top_tb
	import pwmg_pkg::*;
;
	logic clk_sys_i = 1'b0, nrst_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0, prdata_o, q;
	logic pready_o, pslverr_o, pulse_out_pin_a_o, pulse_out_pin_b_o, err;
	logic port_pin_alt_a_i = 1'b1, port_pin_alt_b_i = 1'b1;
	int hi_a, per_a, hi_b, per_b, failures = 0, cmp_count = 0;
	pwmg_top DUT (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .port_pin_alt_a_i(port_pin_alt_a_i),
		.port_pin_alt_b_i(port_pin_alt_b_i), .pulse_out_pin_a_o(pulse_out_pin_a_o),
		.pulse_out_pin_b_o(pulse_out_pin_b_o));
	pwmg_load u_la (.clk_i(clk_sys_i), .pin_i(pulse_out_pin_a_o), .hi_o(hi_a), .per_o(per_a));
	pwmg_load u_lb (.clk_i(clk_sys_i), .pin_i(pulse_out_pin_b_o), .hi_o(hi_b), .per_o(per_b));
	initial forever #4 clk_sys_i = ~clk_sys_i;
	// port data keeps moving so routing checks can tell it from a stuck pin
	always @(posedge clk_sys_i) begin
		port_pin_alt_a_i <= ~port_pin_alt_a_i;
		port_pin_alt_b_i <= port_pin_alt_a_i;
	end
	////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %h %h", $time, got, exp);
		end
	endtask : chk
	// one apb transfer, read data in q
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		do @(posedge clk_sys_i); while (pready_o !== 1'b1);
		q = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : bus
	task automatic cfg(input logic [7:0] n, input logic [7:0] m, input logic [2:0] c);
		bus(1'b1, PWMG_PRESC_OFS, {24'h0, n});
		bus(1'b1, PWMG_DUTY_OFS, {24'h0, m});
		bus(1'b1, PWMG_CTRL_OFS, {29'h0, c});
	endtask : cfg
	task automatic t_regs;
		bus(1'b0, PWMG_PRESC_OFS, 32'h0);
		chk(q, {24'h0, PWMG_PRESC_RST});
		bus(1'b1, PWMG_DUTY_OFS, 32'h1ab);
		bus(1'b0, PWMG_DUTY_OFS, 32'h0);
		chk(q, 32'hab);
		bus(1'b0, 8'h10, 32'h0);
		chk({q[30:0], err}, 32'h1);
	endtask : t_regs
	// full rate on pin a, then a live change of both settings
	task automatic t_fast;
		cfg(8'h00, 8'h03, 3'b011);
		repeat (765) @(posedge clk_sys_i);
		chk(per_a, 255);
		chk(hi_a, 3);
		bus(1'b0, PWMG_STAT_OFS, 32'h0);
		chk(q[0], 1'b1);
		bus(1'b1, PWMG_DUTY_OFS, 32'h5);
		bus(1'b1, PWMG_PRESC_OFS, 32'h1);
		repeat (2040) @(posedge clk_sys_i);
		chk(per_a, 510);
		chk(hi_a, 10);
		bus(1'b1, PWMG_CTRL_OFS, 32'h0);
		bus(1'b0, PWMG_STAT_OFS, 32'h0);
		chk(q, 32'h0);
	endtask : t_fast
	// half rate source routed to pin b
	task automatic t_slow;
		cfg(8'h00, 8'h04, 3'b101);
		repeat (1530) @(posedge clk_sys_i);
		chk(per_b, 510);
		chk(hi_b, 8);
		bus(1'b1, PWMG_CTRL_OFS, 32'h0);
	endtask : t_slow
	task automatic summarize;
		if (failures == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : summarize
	initial begin
		repeat (12) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		t_regs();
		t_fast();
		t_slow();
		summarize();
	end
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		failures++;
		summarize();
	end
endmodule : pwmg_top_tb
